/* hdl/dcdc_params.svh */
`ifndef DCDC_PARAMS_SVH
`define DCDC_PARAMS_SVH

// Encoder clock runs at one sixteenth of the converter rate.
`define DCDC_PHASE_LAST 4'hF
// Offset clamp while dither is on, and while it is off.
`define DCDC_SAT_DITHER 17'h00080
`define DCDC_SAT_PLAIN 17'h00F80
// Full-scale current: fixed base of five steps, trim has 64 units per step.
`define DCDC_BASE_UNITS 12'h140
`define DCDC_STEP_SHIFT 6
// Offset binary bias added to the widened signed code.
`define DCDC_CODE_BIAS 17'h10000
// Segment split of the 17-bit code: 4 upper, 4 middle, 9 binary bits.
`define DCDC_UPPER_LSB 13
`define DCDC_MIDDLE_LSB 9
// Dither magnitude step; the eight values are +-32, +-64, +-96, +-128.
`define DCDC_DITHER_STEP 17'h00020
// Seed and taps of the shared pseudo-random source.
`define DCDC_LFSR_SEED 16'hACE1
`define DCDC_LFSR_TAPS 16'hB400
// Reset values of the segment outputs and of the encoder phase.
`define DCDC_RESET_SEG 15'h0000
`define DCDC_RESET_PHASE 4'h0
// Depth of the sample buffer.
`define DCDC_FIFO_DEPTH 16

`endif

/* hdl/dcdc_pkg.sv */
package dcdc_pkg;
   // Output waveform modes of the converter core.
   typedef enum logic [1:0] {
      DCDC_MODE_ZOH = 2'h0,
      DCDC_MODE_RTZ = 2'h1,
      DCDC_MODE_RF = 2'h2,
      DCDC_MODE_DUAL = 2'h3
   } dcdc_mode_t;
   // Which clock edge the next code belongs to.
   typedef enum logic [1:0] {
      DCDC_SLOT_RISE = 2'b01,
      DCDC_SLOT_FALL = 2'b10
   } dcdc_slot_t;
   // Widened signed code that keeps the full sample range plus offset and dither.
   typedef logic signed [16:0] dcdc_wide_t;
endpackage

/* hdl/dcdc_stream_if.sv */
`timescale 1ns/1ps
// Valid/ready word stream between the buffer and the encoder.
interface dcdc_stream_if #(parameter int W = 32) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface

/* hdl/dcdc_fifo.sv */
`timescale 1ns/1ps
// Sample buffer; read data leave through a register stage.
module dcdc_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   dcdc_stream_if.snk wr,
   dcdc_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];          // Storage, not reset on purpose.
   logic [AW-1:0] wptr, next_wptr;     // Write position.
   logic [AW-1:0] rptr, next_rptr;     // Read position.
   logic [AW:0] count, next_count;     // Words held in storage.
   logic in_ready, next_in_ready;      // Registered so the source sees a flop.
   logic out_valid, next_out_valid;    // Output register holds a word.
   logic [W-1:0] out_data, next_out_data;
   logic push, pop;

   assign wr.ready = in_ready;
   assign rd.valid = out_valid;
   assign rd.data = out_data;

   // Next state: the output register refills whenever it is empty or drained.
   always_comb begin
      push = wr.valid && in_ready;
      pop = (count != '0) && (!out_valid || rd.ready);
      next_wptr = push ? AW'(wptr + 1'b1) : wptr;
      next_rptr = pop ? AW'(rptr + 1'b1) : rptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
      next_out_valid = pop ? 1'b1 : (rd.ready ? 1'b0 : out_valid);
      next_out_data = pop ? mem[rptr] : out_data;
      // Ready follows the next count, so it drops in the cycle storage fills, which keeps full honest with a flopped ready.
      next_in_ready = (next_count < (AW+1)'(DEPTH));
   end

   // Registers only.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
         in_ready <= next_in_ready;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
      end
   end

   // Storage write.
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wptr] <= wr.data;
      end
   end

   chk_fifo_full_refuse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (count == (AW+1)'(DEPTH)) |-> !in_ready)
      else $error("Buffer accepts words while full.");
   chk_fifo_drain_valid: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (count != '0 && !out_valid) |=> out_valid)
      else $error("Buffer output did not refill.");
   cov_fifo_full: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      count == (AW+1)'(DEPTH));
endmodule

/* hdl/dcdc_core.sv */
`timescale 1ns/1ps
`include "dcdc_params.svh"
module dcdc_core #(
   parameter int DEPTH = `DCDC_FIFO_DEPTH
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [15:0] sample_a_i,
   input wire logic [15:0] sample_b_i,
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   input wire logic core_ready_i,
   input wire dcdc_pkg::dcdc_mode_t output_mode_i,
   input wire logic sysref_i,
   input wire logic [3:0] full_scale_step_a_i,
   input wire logic [3:0] full_scale_step_b_i,
   input wire logic [5:0] full_scale_trim_a_i,
   input wire logic [5:0] full_scale_trim_b_i,
   input wire logic current_double_enable_i,
   input wire logic element_shuffling_i,
   input wire logic [1:0] shuffle_setting_a_i,
   input wire logic [1:0] shuffle_setting_b_i,
   input wire logic shuffle_activity_adjust_i,
   input wire logic shuffle_dither_enable_i,
   input wire logic [1:0] dither_rate_a_i,
   input wire logic [1:0] dither_rate_b_i,
   input wire logic [15:0] output_offset_word_a_i,
   input wire logic [15:0] output_offset_word_b_i,
   input wire logic coding_64b66b_i,
   input wire logic [3:0] link_e_i,
   input wire logic [7:0] link_f_i,
   input wire logic [11:0] link_k_i,
   output logic [11:0] full_scale_units_a_o,
   output logic [11:0] full_scale_units_b_o,
   output logic [11:0] multiframe_k_o,
   output logic [3:0] encoder_phase_o,
   output logic sysref_misaligned_o,
   output logic code_valid_o,
   output logic edge_fall_o,
   output logic [1:0][14:0] upper_seg_o,
   output logic [1:0][14:0] middle_segments_o,
   output logic [1:0][8:0] low_bits_o,
   output logic [1:0][3:0] dither_src_o
);
   // Full-scale current in 1/64 step units, doubled by the shared bit.
   function automatic logic [11:0] fs_units(input logic [3:0] step, input logic [5:0] trim,
                                            input logic dbl);
      logic [11:0] u;
      u = `DCDC_BASE_UNITS + {2'h0, step, 6'h00} + {6'h00, trim};
      return dbl ? {u[10:0], 1'b0} : u;
   endfunction

   // Clamp a signed offset word to plus or minus the limit.
   function automatic dcdc_pkg::dcdc_wide_t clamp(input logic [15:0] w, input logic [16:0] lim);
      dcdc_pkg::dcdc_wide_t s;
      s = dcdc_pkg::dcdc_wide_t'(signed'(w));
      if (s > signed'(lim)) begin
         return signed'(lim);
      end else if (s < -signed'(lim)) begin
         return -signed'(lim);
      end
      return s;
   endfunction

   // Thermometer code of a 4-bit count, rotated right by a pointer below 15.
   function automatic logic [14:0] therm_rot(input logic [3:0] cnt, input logic [3:0] ptr);
      logic [15:0] t;
      logic [29:0] d;
      t = (16'h0001 << cnt) - 16'h0001;
      d = {t[14:0], t[14:0]} >> ptr;
      return d[14:0];
   endfunction

   // Advance a segment pointer modulo 15.
   function automatic logic [3:0] ptr_add(input logic [3:0] p, input logic [3:0] s);
      logic [4:0] n;
      n = {1'b0, p} + {1'b0, s};
      n = (n >= 5'h0F) ? n - 5'h0F : n;
      n = (n >= 5'h0F) ? n - 5'h0F : n;
      return n[3:0];
   endfunction

   // Dither value: index bit 2 is the sign, bits 1:0 pick 32, 64, 96 or 128.
   function automatic dcdc_pkg::dcdc_wide_t dith_val(input logic [2:0] idx);
      dcdc_pkg::dcdc_wide_t m;
      m = signed'(17'(`DCDC_DITHER_STEP * ({15'h0000, idx[1:0]} + 17'h00001)));
      return idx[2] ? -m : m;
   endfunction

   dcdc_stream_if #(.W(32)) in_if ();
   dcdc_stream_if #(.W(32)) out_if ();
   logic pop;

   assign in_if.valid = sample_valid_i;
   assign in_if.data = {sample_b_i, sample_a_i};
   assign sample_ready_o = in_if.ready;
   assign out_if.ready = core_ready_i;
   assign pop = out_if.valid && core_ready_i;

   // Samples wait here; the converter stalls the buffer through core_ready_i.
   dcdc_fifo #(.W(32), .DEPTH(DEPTH)) u_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wr(in_if.snk),
      .rd(out_if.src)
   );

   // Per-channel views of the settings.
   logic [1:0][15:0] sample_ch, offset_ch;
   logic [1:0][1:0] shuf_set, dith_set;
   assign sample_ch = out_if.data;
   assign offset_ch = {output_offset_word_b_i, output_offset_word_a_i};
   assign shuf_set = {shuffle_setting_b_i, shuffle_setting_a_i};
   assign dith_set = {dither_rate_b_i, dither_rate_a_i};

   // Encoder phase, shared random source and SYSREF edge tracking.
   logic [3:0] phase, next_phase;
   logic [15:0] lfsr, next_lfsr;
   logic sysref_q, next_sysref_q;
   logic seen_edge, next_seen_edge;
   logic misaligned, next_misaligned;
   logic sysref_rise, enc_tick;

   // The divided encoder clock restarts on each SYSREF rising edge so all channels line up.
   always_comb begin
      sysref_rise = sysref_i && !sysref_q;
      next_sysref_q = sysref_i;
      next_phase = sysref_rise ? 4'h0 : 4'(phase + 4'h1);
      enc_tick = (phase == `DCDC_PHASE_LAST);
      next_lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? `DCDC_LFSR_TAPS : 16'h0000);
      next_seen_edge = seen_edge || sysref_rise;
      // An aligned period lands exactly where the phase wraps.
      next_misaligned = (sysref_rise && seen_edge) ? (phase != `DCDC_PHASE_LAST)
                                                   : misaligned;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase <= `DCDC_RESET_PHASE;
         lfsr <= `DCDC_LFSR_SEED;
         sysref_q <= 1'b0;
         seen_edge <= 1'b0;
         misaligned <= 1'b0;
      end else begin
         phase <= next_phase;
         lfsr <= next_lfsr;
         sysref_q <= next_sysref_q;
         seen_edge <= next_seen_edge;
         misaligned <= next_misaligned;
      end
   end

   // Shuffle pointers, rate counters and dither selection per channel.
   logic [1:0][3:0] ptr_up, next_ptr_up, ptr_mid, next_ptr_mid;
   logic [1:0][2:0] shuf_cnt, next_shuf_cnt, dith_cnt, next_dith_cnt;
   logic [1:0][2:0] dith_idx, next_dith_idx;
   logic [1:0][3:0] last_upper, next_last_upper;
   logic [1:0][3:0] up_cnt;
   logic [1:0][2:0] shuf_mask, dith_mask;
   logic [3:0] shuf_step;
   logic [1:0] shuf_go;

   always_comb begin
      // Full activity moves by a random amount; data-dependent mode moves the upper pointer
      // one segment and only when the upper code changed, trading whitening for noise.
      shuf_step = shuffle_activity_adjust_i ? 4'h1 : ptr_add(lfsr[3:0], 4'h0);
      for (int c = 0; c < 2; c++) begin
         shuf_mask[c] = 3'((4'h1 << shuf_set[c]) - 4'h1);
         dith_mask[c] = 3'((4'h1 << dith_set[c]) - 4'h1);
         next_shuf_cnt[c] = shuf_cnt[c];
         next_ptr_up[c] = ptr_up[c];
         next_ptr_mid[c] = ptr_mid[c];
         shuf_go[c] = 1'b0;
         if (enc_tick) begin
            next_shuf_cnt[c] = (shuf_cnt[c] >= shuf_mask[c]) ? 3'h0 : 3'(shuf_cnt[c] + 3'h1);
            shuf_go[c] = element_shuffling_i && (shuf_cnt[c] >= shuf_mask[c]) &&
                         (!shuffle_activity_adjust_i || up_cnt[c] != last_upper[c]);
         end
         if (shuf_go[c]) begin
            next_ptr_up[c] = ptr_add(ptr_up[c], shuf_step);
            next_ptr_mid[c] = ptr_add(ptr_mid[c], ptr_add(shuf_step, lfsr[7:4]));
         end
         next_last_upper[c] = enc_tick ? up_cnt[c] : last_upper[c];
         // Dither index changes every 2^setting cycles.
         next_dith_cnt[c] = (dith_cnt[c] >= dith_mask[c]) ? 3'h0 : 3'(dith_cnt[c] + 3'h1);
         next_dith_idx[c] = (dith_cnt[c] >= dith_mask[c]) ?
                            (lfsr[10:8] ^ 3'(c)) : dith_idx[c];
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ptr_up <= '0;
         ptr_mid <= '0;
         shuf_cnt <= '0;
         dith_cnt <= '0;
         dith_idx <= '0;
         last_upper <= '0;
      end else begin
         ptr_up <= next_ptr_up;
         ptr_mid <= next_ptr_mid;
         shuf_cnt <= next_shuf_cnt;
         dith_cnt <= next_dith_cnt;
         dith_idx <= next_dith_idx;
         last_upper <= next_last_upper;
      end
   end

   // Data path: clamp, add, bias and split each channel code.
   dcdc_pkg::dcdc_wide_t [1:0] off_sat, wide;
   logic [1:0][16:0] obin;
   logic [1:0][14:0] next_upper, next_middle;
   logic [1:0][8:0] next_low;
   logic [1:0][3:0] next_dsrc;

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         off_sat[c] = clamp(offset_ch[c], shuffle_dither_enable_i ? `DCDC_SAT_DITHER
                                                                  : `DCDC_SAT_PLAIN);
         // The 17-bit path holds sample plus offset, so no sample code is lost.
         wide[c] = dcdc_pkg::dcdc_wide_t'(signed'(sample_ch[c])) + off_sat[c];
         if (shuffle_dither_enable_i) begin
            wide[c] = wide[c] + dith_val(dith_idx[c]);
         end
         obin[c] = 17'(wide[c]) + `DCDC_CODE_BIAS;
         up_cnt[c] = obin[c][16:`DCDC_UPPER_LSB];
         next_upper[c] = therm_rot(up_cnt[c], ptr_up[c]);
         next_middle[c] = therm_rot(obin[c][`DCDC_UPPER_LSB-1:`DCDC_MIDDLE_LSB], ptr_mid[c]);
         next_low[c] = obin[c][`DCDC_MIDDLE_LSB-1:0];
         // The extra sources subtract the same value; bit 3 says they are in use.
         next_dsrc[c] = shuffle_dither_enable_i ? {1'b1, dith_idx[c]} : 4'h0;
      end
   end

   // Output registers and the dual-edge slot.
   dcdc_pkg::dcdc_slot_t slot, next_slot;
   logic next_code_valid, next_edge_fall;
   logic [11:0] next_units_a, next_units_b, next_k;

   always_comb begin
      next_slot = slot;
      if (pop) begin
         unique case (slot)
            dcdc_pkg::DCDC_SLOT_RISE: begin
               // Only dual-edge mode places the next word on the falling edge.
               next_slot = (output_mode_i == dcdc_pkg::DCDC_MODE_DUAL) ?
                           dcdc_pkg::DCDC_SLOT_FALL : dcdc_pkg::DCDC_SLOT_RISE;
            end
            dcdc_pkg::DCDC_SLOT_FALL: begin
               next_slot = dcdc_pkg::DCDC_SLOT_RISE;
            end
            default: begin
               next_slot = dcdc_pkg::DCDC_SLOT_RISE;
            end
         endcase
      end
      next_code_valid = pop;
      next_edge_fall = pop ? (slot == dcdc_pkg::DCDC_SLOT_FALL) : edge_fall_o;
      next_units_a = fs_units(full_scale_step_a_i, full_scale_trim_a_i,
                              current_double_enable_i);
      next_units_b = fs_units(full_scale_step_b_i, full_scale_trim_b_i,
                              current_double_enable_i);
      // A zero frame length would divide by zero, so K reads zero then.
      next_k = !coding_64b66b_i ? link_k_i :
               (link_f_i == 8'h00) ? 12'h000 : 12'({link_e_i, 8'h00} / link_f_i);
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         slot <= dcdc_pkg::DCDC_SLOT_RISE;
         code_valid_o <= 1'b0;
         edge_fall_o <= 1'b0;
         upper_seg_o <= {2{`DCDC_RESET_SEG}};
         middle_segments_o <= {2{`DCDC_RESET_SEG}};
         low_bits_o <= '0;
         dither_src_o <= '0;
         full_scale_units_a_o <= '0;
         full_scale_units_b_o <= '0;
         multiframe_k_o <= '0;
      end else begin
         slot <= next_slot;
         code_valid_o <= next_code_valid;
         edge_fall_o <= next_edge_fall;
         // Codes hold between samples so a stalled converter keeps its value.
         upper_seg_o <= pop ? next_upper : upper_seg_o;
         middle_segments_o <= pop ? next_middle : middle_segments_o;
         low_bits_o <= pop ? next_low : low_bits_o;
         dither_src_o <= pop ? next_dsrc : dither_src_o;
         full_scale_units_a_o <= next_units_a;
         full_scale_units_b_o <= next_units_b;
         multiframe_k_o <= next_k;
      end
   end

   assign encoder_phase_o = phase;
   assign sysref_misaligned_o = misaligned;

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   chk_offset_dither_clamp: assert property (
      shuffle_dither_enable_i |-> (off_sat[0] <= 17'sd128 && off_sat[0] >= -17'sd128))
      else $error("Offset exceeds the dither clamp.");
   chk_offset_plain_clamp: assert property (
      !shuffle_dither_enable_i |-> (off_sat[1] <= 17'sd3968 && off_sat[1] >= -17'sd3968))
      else $error("Offset exceeds the plain clamp.");
   chk_phase_sysref_align: assert property (
      $rose(sysref_i) |=> phase == 4'h0 ##15 (phase == 4'hF || $rose(sysref_i)))
      else $error("Encoder phase not aligned to SYSREF.");
   // The edge on which reset lets go is skipped, since the flops still hold zero there.
   chk_current_units_map: assert property (
      !rst_i |=> full_scale_units_a_o ==
      (($past(current_double_enable_i) ? 12'h002 : 12'h001) *
       (12'h140 + 12'h040 * $past(full_scale_step_a_i) + $past(full_scale_trim_a_i))))
      else $error("Full-scale units wrong.");
   chk_upper_therm_count: assert property (
      pop |=> $countones(upper_seg_o[0]) == $past(up_cnt[0]))
      else $error("Upper segment count does not match code.");
   chk_shuffle_off_hold: assert property (
      !element_shuffling_i [*2] |-> $stable(ptr_up))
      else $error("Segments shuffled while shuffling is off.");
   chk_dither_off_quiet: assert property (
      code_valid_o && !$past(shuffle_dither_enable_i) |-> dither_src_o == '0)
      else $error("Dither sources active while dither is off.");
   chk_dual_edge_alternate: assert property (
      (pop && slot == dcdc_pkg::DCDC_SLOT_RISE &&
       output_mode_i == dcdc_pkg::DCDC_MODE_DUAL) ##1 pop |=> edge_fall_o)
      else $error("Dual-edge sample not placed on falling edge.");
   chk_dither_rate_hold: assert property (
      dith_set[0] == 2'h3 && dith_cnt[0] == 3'h0 |=> $stable(dith_idx[0]) [*6])
      else $error("Dither changed faster than its rate.");

   cov_dual_edge_fall: cover property (code_valid_o && edge_fall_o);
   cov_sysref_realign: cover property ($rose(sysref_i) && phase != 4'hF);
   cov_offset_clamped: cover property (signed'(offset_ch[0]) > 16'sd128 &&
                                       shuffle_dither_enable_i);
   cov_shuffle_step: cover property (shuf_go[0]);
endmodule

/* tb/dcdc_src_model.sv */
`timescale 1ns/1ps
// Upstream pair source and SYSREF generator facing the converter core.
module dcdc_src_model (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic sample_ready_i,
   output logic [15:0] sample_a_o,
   output logic [15:0] sample_b_o,
   output logic sample_valid_o,
   output logic sysref_o,
   output logic [3:0] ref_cnt_o
);
   // A period of exactly 16 clocks keeps the encoder divider in step. The bench stands
   // for direct-synthesis use, where the link-derived period limits are waived.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_cnt_o <= 4'h0;
         sysref_o <= 1'b0;
      end else begin
         ref_cnt_o <= ref_cnt_o + 4'h1;
         sysref_o <= (ref_cnt_o == 4'hF);
      end
   end
   // The source is idle at time zero.
   initial begin
      sample_valid_o = 1'b0;
      sample_a_o = 16'h0000;
      sample_b_o = 16'h0000;
   end
   // Offer a pair and hold it until an edge takes it or the bound runs out.
   task automatic send(input logic [15:0] a, input logic [15:0] b, input int lim, output bit ok);
      int n;
      sample_a_o <= a;
      sample_b_o <= b;
      sample_valid_o <= 1'b1;
      ok = 1'b0;
      for (n = 0; n < lim && !ok; n++) begin
         @(posedge sys_clk_i);
         ok = sample_ready_i;
      end
   endtask
   // Released lines show the inverse, so a stale pair is never mistaken for data.
   task automatic idle();
      sample_valid_o <= 1'b0;
      sample_a_o <= ~sample_a_o;
      sample_b_o <= ~sample_b_o;
   endtask
endmodule

/* tb/dcdc_core_test.sv */
`timescale 1ns/1ps
// Bench for the converter control core; settings are driven here.
module dcdc_core_test;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic core_ready = 1'b0;
   dcdc_pkg::dcdc_mode_t mode = dcdc_pkg::DCDC_MODE_DUAL;
   logic [3:0] step_a = 4'h0, step_b = 4'h0, link_e = 4'h3, ref_cnt, phase;
   logic [5:0] trim_a = 6'h00, trim_b = 6'h00;
   logic dbl = 1'b0, shuf = 1'b1, adj = 1'b1, dith = 1'b0, c64 = 1'b1;
   logic [15:0] ofs_a = 16'h0000, ofs_b = 16'h0000, sa, sb;
   logic [7:0] link_f = 8'h02;
   logic [1:0] drate = 2'h0;
   logic valid, ready, sysref, code_valid, fall, misal;
   logic [11:0] units_a, units_b, kval;
   logic [1:0][14:0] upper, middle;
   logic [1:0][8:0] low;
   logic [1:0][3:0] dsrc;
   // Offset cases: boundaries of both clamps, full-scale samples.
   logic [15:0] cs [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h7FFF, 16'h8000, 16'h0100};
   logic [15:0] co [6] = '{16'h03E8, 16'h1388, 16'hEC78, 16'h0F80, 16'hFF7F, 16'h1388};
   logic cd [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   int n_mismatch = 0;
   int num_checks = 0;
   int i;
   bit ok;

   // The clock runs at 50 MHz and stands for the converter clock at the core rate.
   always #10 sys_clk_i = ~sys_clk_i;

   dcdc_src_model i_dcdc_src_model (.sys_clk_i, .rst_i, .sample_ready_i(ready),
      .sample_a_o(sa), .sample_b_o(sb), .sample_valid_o(valid), .sysref_o(sysref),
      .ref_cnt_o(ref_cnt));
   dcdc_core i_dcdc_core (.sys_clk_i, .rst_i, .sample_a_i(sa), .sample_b_i(sb),
      .sample_valid_i(valid), .sample_ready_o(ready), .core_ready_i(core_ready),
      .output_mode_i(mode), .sysref_i(sysref), .full_scale_step_a_i(step_a),
      .full_scale_step_b_i(step_b), .full_scale_trim_a_i(trim_a),
      .full_scale_trim_b_i(trim_b), .current_double_enable_i(dbl),
      .element_shuffling_i(shuf), .shuffle_setting_a_i(2'h0), .shuffle_setting_b_i(2'h1),
      .shuffle_activity_adjust_i(adj), .shuffle_dither_enable_i(dith),
      .dither_rate_a_i(drate), .dither_rate_b_i(2'h1), .output_offset_word_a_i(ofs_a),
      .output_offset_word_b_i(ofs_b), .coding_64b66b_i(c64), .link_e_i(link_e),
      .link_f_i(link_f), .link_k_i(12'h0A5), .full_scale_units_a_o(units_a),
      .full_scale_units_b_o(units_b), .multiframe_k_o(kval), .encoder_phase_o(phase),
      .sysref_misaligned_o(misal), .code_valid_o(code_valid), .edge_fall_o(fall),
      .upper_seg_o(upper), .middle_segments_o(middle), .low_bits_o(low),
      .dither_src_o(dsrc));

   // Counts every comparison and reports a mismatch at once.
   task automatic cmp(input logic [16:0] g, input logic [16:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // The single place where the run ends.
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Waits for the next code pulse; a missing code ends the run.
   task automatic wait_code();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (code_valid !== 1'b1 && n < 400);
      if (code_valid !== 1'b1) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask

   // Expected offset-binary code: clamp first, then a signed sum.
   function automatic logic [16:0] obin(input logic [15:0] s, input logic [15:0] o,
         input logic d, input int dv);
      int lim;
      int c;
      lim = d ? 128 : 3968;
      c = $signed(o);
      if (c > lim) c = lim;
      if (c < -lim) c = -lim;
      return 17'($signed(s) + c + dv + 65536);
   endfunction

   // One pair through the encoder; segment counts do not depend on shuffling.
   task automatic code_case(input logic [15:0] s, input logic [15:0] o, input logic d);
      logic [16:0] e;
      int dv;
      ofs_a <= o;
      ofs_b <= o;
      dith <= d;
      i_dcdc_src_model.send(s, s, 400, ok);
      i_dcdc_src_model.idle();
      // A pair that is never taken ends the run like any other timeout.
      if (!ok) begin
         n_mismatch++;
         report_and_stop();
      end
      wait_code();
      dv = dsrc[0][3] ? (int'(dsrc[0][1:0]) + 1) * 32 : 0;
      if (dsrc[0][2]) dv = -dv;
      e = obin(s, o, d, dv);
      cmp(17'(dsrc[0][3]), 17'(d));
      cmp(17'($countones(upper[0])), 17'(e[16:13]));
      cmp(17'($countones(middle[0])), 17'(e[12:9]));
      cmp(17'(low[0]), 17'(e[8:0]));
   endtask

   initial begin
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      // Encoder stalled: the buffer and its output register must fill, then refuse.
      for (i = 0; i < 40; i++) begin
         i_dcdc_src_model.send(16'(i), 16'(i), 4, ok);
         if (!ok) break;
      end
      i_dcdc_src_model.idle();
      cmp(17'(i), 17'h00011);
      core_ready <= 1'b1;
      for (i = 0; i < 17; i++) begin
         wait_code();
         cmp(17'(low[0]), 17'(i));
         cmp(17'(low[1]), 17'(i));
         cmp(17'(fall), 17'(i % 2));
      end
      // Every coarse code, with trim and doubling varied alongside.
      for (i = 0; i < 16; i++) begin
         step_a <= 4'(i);
         trim_a <= 6'(i * 4 + 3);
         dbl <= i[0];
         step_b <= 4'(15 - i);
         trim_b <= 6'(60 - i * 4);
         // Shuffling is switched off in four-cycle stretches so the hold check gets work.
         shuf <= i[1];
         repeat (2) @(posedge sys_clk_i);
         cmp(17'(units_a), 17'((323 + 68 * i) << i[0]));
         cmp(17'(units_b), 17'((1340 - 68 * i) << i[0]));
      end
      cmp(17'(kval), 17'h00180);
      // A zero frame length must give zero rather than a divide fault.
      link_f <= 8'h00;
      repeat (2) @(posedge sys_clk_i);
      cmp(17'(kval), 17'h00000);
      c64 <= 1'b0;
      drate <= 2'h3;
      repeat (2) @(posedge sys_clk_i);
      cmp(17'(kval), 17'h000A5);
      // The phase wraps at four bits, so the difference is cut back before widening.
      cmp(17'(phase), 17'(4'(ref_cnt - 4'h1)));
      cmp(17'(misal), 17'h00000);
      for (i = 0; i < 6; i++) begin
         mode <= dcdc_pkg::dcdc_mode_t'(i % 4);
         adj <= i[0];
         code_case(cs[i], co[i], cd[i]);
      end
      report_and_stop();
   end
endmodule
